// ==== ssio_channel.sv ====
// One channel of a clocked synchronous serial port with frame sync, Wishbone slave.
// Assumes the serial peer supplies both bit clocks, well below clk_i.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module ssio_channel
    import ssio_pkg::*;
#(
    parameter int DATA_W = SSIO_DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [SSIO_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic tx_data_pin_o,
    output logic tx_data_pin_oe_o,
    input wire logic tx_clock_pin_i,
    input wire logic tx_sync_pin_i,
    output logic tx_sync_pin_o,
    output logic tx_sync_pin_oe_o,
    input wire logic rx_data_pin_i,
    input wire logic rx_clock_pin_i,
    input wire logic rx_sync_pin_i,
    output logic tx_empty_irq_o,
    output logic rx_full_irq_o,
    output logic tx_overrun_irq_o,
    output logic rx_overrun_irq_o
);
    typedef enum logic [1:0] {SSIO_TX_IDLE, SSIO_TX_SYNC, SSIO_TX_SHIFT} ssio_tx_state_t;

    logic [SSIO_CTL_W-1:0] control_reg;
    logic [SSIO_FLG_W-1:0] flags_reg;
    logic [SSIO_FLG_W-1:0] flags_next;
    logic [SSIO_FLG_W-1:0] seen_reg;
    logic [DATA_W-1:0] transmit_holding_reg;
    logic [DATA_W-1:0] receive_holding_reg;
    logic [DATA_W-1:0] tx_shifter_reg;
    logic [DATA_W-1:0] rx_shifter_reg;
    logic [SSIO_CNT_W-1:0] tx_count_reg;
    logic [SSIO_CNT_W-1:0] rx_count_reg;
    ssio_tx_state_t tx_state_reg;
    logic rx_active_reg;
    logic rx_started_reg;
    logic tx_sync_out_reg;
    logic wb_ack_reg;
    logic [31:0] wb_dat_reg;

    logic tx_clk_rise;
    logic rx_clk_fall;
    logic tx_sync_lvl;
    logic rx_sync_lvl;
    logic rx_data_lvl;
    logic tx_enable;
    logic rx_enable;
    logic word_long;
    logic interval_mode;
    logic internal_sync;
    logic [SSIO_CNT_W-1:0] word_bits;
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic tx_load;
    logic tx_word_end;
    logic rx_word_end;
    logic [DATA_W-1:0] rx_word;

    ssio_edge_sync u_tx_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(tx_clock_pin_i),
        .level_o(),
        .rise_o(tx_clk_rise),
        .fall_o()
    );

    ssio_edge_sync u_tx_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(tx_sync_pin_i),
        .level_o(tx_sync_lvl),
        .rise_o(),
        .fall_o()
    );

    ssio_edge_sync u_rx_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(rx_clock_pin_i),
        .level_o(),
        .rise_o(),
        .fall_o(rx_clk_fall)
    );

    ssio_edge_sync u_rx_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(rx_sync_pin_i),
        .level_o(rx_sync_lvl),
        .rise_o(),
        .fall_o()
    );

    // Data takes the same two stages as its clock, so they stay aligned.
    ssio_edge_sync u_rx_data (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(rx_data_pin_i),
        .level_o(rx_data_lvl),
        .rise_o(),
        .fall_o()
    );

    assign tx_enable = control_reg[SSIO_CTL_TX_ENABLE];
    assign rx_enable = control_reg[SSIO_CTL_RX_ENABLE];
    assign word_long = control_reg[SSIO_CTL_WORD_LENGTH_SEL];
    assign interval_mode = control_reg[SSIO_CTL_SYNC_EVERY_WORD];
    assign internal_sync = control_reg[SSIO_CTL_TX_SYNC_SOURCE];
    assign word_bits = word_long ? SSIO_BITS_LONG : SSIO_BITS_SHORT;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
    assign bus_wr = bus_req & wb_we_i;
    assign bus_rd = bus_req & ~wb_we_i;

    // Bus answers one cycle after the request; unmapped addresses read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_reg <= 1'b0;
        end else begin
            wb_ack_reg <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_reg <= 32'h0000_0000;
        end else if (bus_rd) begin
            unique case (wb_adr_i)
                SSIO_OFS_RX_HOLD: wb_dat_reg <= {16'h0000, receive_holding_reg};
                SSIO_OFS_TX_HOLD: wb_dat_reg <= {16'h0000, transmit_holding_reg};
                SSIO_OFS_CONTROL: wb_dat_reg <= {25'h0000000, control_reg};
                SSIO_OFS_FLAGS: wb_dat_reg <= {28'h0000000, flags_reg};
                default: wb_dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = wb_dat_reg;

    // Writes to reserved control bits are dropped so they always read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_reg <= SSIO_CTL_RESET;
        end else if (bus_wr && wb_adr_i == SSIO_OFS_CONTROL && wb_sel_i[0]) begin
            control_reg <= wb_dat_i[SSIO_CTL_W-1:0];
        end
    end

    // A write while the flag is clear silently replaces the pending word.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transmit_holding_reg <= SSIO_HOLD_RESET;
        end else if (bus_wr && wb_adr_i == SSIO_OFS_TX_HOLD) begin
            if (wb_sel_i[0]) begin
                transmit_holding_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                transmit_holding_reg[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // Remembers which flags software has read as one since its last flag write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_reg <= '0;
        end else if (bus_wr && wb_adr_i == SSIO_OFS_FLAGS && wb_sel_i[0]) begin
            seen_reg <= '0;
        end else if (bus_rd && wb_adr_i == SSIO_OFS_FLAGS) begin
            seen_reg <= seen_reg | flags_reg;
        end
    end

    // Transmit sequencer: waits for sync, then shifts one bit per clock rise.
    assign tx_word_end = tx_clk_rise && tx_state_reg == SSIO_TX_SHIFT && tx_count_reg == 5'h01;
    always_comb begin
        tx_load = 1'b0;
        if (tx_enable && tx_clk_rise) begin
            unique case (tx_state_reg)
                SSIO_TX_IDLE: tx_load = ~internal_sync & tx_sync_lvl;
                SSIO_TX_SYNC: tx_load = 1'b1;
                // The last bit ends on the next word's first rise, so a sync there loads at once.
                SSIO_TX_SHIFT: tx_load = tx_count_reg == 5'h01
                    && (!interval_mode || (~internal_sync & tx_sync_lvl));
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_enable) begin
            tx_state_reg <= SSIO_TX_IDLE;
            tx_count_reg <= '0;
            tx_sync_out_reg <= 1'b0;
        end else if (tx_clk_rise) begin
            tx_sync_out_reg <= 1'b0;
            if (tx_load) begin
                tx_state_reg <= SSIO_TX_SHIFT;
                tx_count_reg <= word_bits;
            end else if (tx_word_end) begin
                tx_state_reg <= SSIO_TX_IDLE;
                tx_count_reg <= '0;
            end else if (tx_state_reg == SSIO_TX_SHIFT) begin
                tx_count_reg <= tx_count_reg - 5'h01;
            end else if (tx_state_reg == SSIO_TX_IDLE && internal_sync
                         && !flags_reg[SSIO_FLG_TX_EMPTY]) begin
                // Internal sync is a one-bit-clock pulse ahead of the word.
                tx_state_reg <= SSIO_TX_SYNC;
                tx_sync_out_reg <= 1'b1;
            end
        end
    end

    // Short words are moved into the top byte so the MSB-first path is shared.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_shifter_reg <= '0;
        end else if (tx_load) begin
            tx_shifter_reg <= word_long ? transmit_holding_reg
                                        : {transmit_holding_reg[7:0], 8'h00};
        end else if (tx_clk_rise && tx_state_reg == SSIO_TX_SHIFT) begin
            tx_shifter_reg <= {tx_shifter_reg[DATA_W-2:0], 1'b0};
        end
    end

    assign tx_data_pin_o = tx_shifter_reg[DATA_W-1];
    assign tx_data_pin_oe_o = tx_enable;
    assign tx_sync_pin_o = tx_sync_out_reg;
    assign tx_sync_pin_oe_o = tx_enable & internal_sync;

    // Receive sequencer: first word waits for sync; continuous mode stays armed.
    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_enable) begin
            rx_active_reg <= 1'b0;
            rx_started_reg <= 1'b0;
            rx_count_reg <= '0;
            rx_shifter_reg <= '0;
        end else if (rx_clk_fall) begin
            if (rx_active_reg || rx_sync_lvl || (rx_started_reg && !interval_mode)) begin
                rx_shifter_reg <= {rx_shifter_reg[DATA_W-2:0], rx_data_lvl};
                rx_started_reg <= 1'b1;
                if (rx_word_end) begin
                    rx_active_reg <= 1'b0;
                    rx_count_reg <= '0;
                end else begin
                    rx_active_reg <= 1'b1;
                    rx_count_reg <= rx_count_reg + 5'h01;
                end
            end
        end
    end

    assign rx_word_end = rx_clk_fall && rx_enable && rx_count_reg == word_bits - 5'h01
                         && (rx_active_reg || rx_sync_lvl || !interval_mode);
    assign rx_word = {rx_shifter_reg[DATA_W-2:0], rx_data_lvl};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            receive_holding_reg <= SSIO_HOLD_RESET;
        end else if (rx_word_end) begin
            receive_holding_reg <= word_long ? rx_word : {8'h00, rx_word[7:0]};
        end
    end

    // Hardware set wins over a software clear landing in the same cycle.
    always_comb begin
        flags_next = flags_reg;
        if (bus_wr && wb_adr_i == SSIO_OFS_FLAGS && wb_sel_i[0]) begin
            flags_next = flags_reg & ~(seen_reg & ~wb_dat_i[SSIO_FLG_W-1:0]);
        end
        if (tx_load) begin
            flags_next[SSIO_FLG_TX_EMPTY] = 1'b1;
            if (flags_reg[SSIO_FLG_TX_EMPTY]) begin
                flags_next[SSIO_FLG_TX_OVERRUN] = 1'b1;
            end
        end
        if (!tx_enable) begin
            flags_next[SSIO_FLG_TX_EMPTY] = 1'b1;
        end
        if (!rx_enable) begin
            flags_next[SSIO_FLG_RX_FULL] = 1'b0;
        end else if (rx_word_end) begin
            flags_next[SSIO_FLG_RX_FULL] = 1'b1;
            if (flags_reg[SSIO_FLG_RX_FULL]) begin
                flags_next[SSIO_FLG_RX_OVERRUN] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= SSIO_FLG_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign tx_empty_irq_o = flags_reg[SSIO_FLG_TX_EMPTY]
                            & control_reg[SSIO_CTL_TX_EMPTY_IRQ_EN];
    assign rx_full_irq_o = flags_reg[SSIO_FLG_RX_FULL]
                           & control_reg[SSIO_CTL_RX_FULL_IRQ_EN];
    assign tx_overrun_irq_o = flags_reg[SSIO_FLG_TX_OVERRUN];
    assign rx_overrun_irq_o = flags_reg[SSIO_FLG_RX_OVERRUN];
endmodule

// ==== ssio_pkg.sv ====
// Constants shared by the synchronous serial channel.
// Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
package ssio_pkg;

    localparam int SSIO_ADDR_W = 4;
    localparam int SSIO_DATA_W = 16;
    localparam int SSIO_CNT_W = 5;

    localparam logic [SSIO_ADDR_W-1:0] SSIO_OFS_RX_HOLD = 4'h0;
    localparam logic [SSIO_ADDR_W-1:0] SSIO_OFS_TX_HOLD = 4'h4;
    localparam logic [SSIO_ADDR_W-1:0] SSIO_OFS_CONTROL = 4'h8;
    localparam logic [SSIO_ADDR_W-1:0] SSIO_OFS_FLAGS = 4'hc;

    localparam int SSIO_CTL_RX_ENABLE = 0;
    localparam int SSIO_CTL_TX_ENABLE = 1;
    localparam int SSIO_CTL_RX_FULL_IRQ_EN = 2;
    localparam int SSIO_CTL_TX_EMPTY_IRQ_EN = 3;
    localparam int SSIO_CTL_WORD_LENGTH_SEL = 4;
    localparam int SSIO_CTL_SYNC_EVERY_WORD = 5;
    localparam int SSIO_CTL_TX_SYNC_SOURCE = 6;
    localparam int SSIO_CTL_W = 7;

    localparam int SSIO_FLG_RX_FULL = 0;
    localparam int SSIO_FLG_TX_EMPTY = 1;
    localparam int SSIO_FLG_RX_OVERRUN = 2;
    localparam int SSIO_FLG_TX_OVERRUN = 3;
    localparam int SSIO_FLG_W = 4;

    localparam logic [SSIO_CTL_W-1:0] SSIO_CTL_RESET = 7'h00;
    localparam logic [SSIO_FLG_W-1:0] SSIO_FLG_RESET = 4'h2;
    localparam logic [SSIO_DATA_W-1:0] SSIO_HOLD_RESET = 16'h0000;

    localparam logic [SSIO_CNT_W-1:0] SSIO_BITS_SHORT = 5'h08;
    localparam logic [SSIO_CNT_W-1:0] SSIO_BITS_LONG = 5'h10;

endpackage

// ==== ssio_edge_sync.sv ====
// Two-stage synchroniser for one pin, with edge pulses taken after it.
// Assumes the input is asynchronous to clk_i and slower than half its rate.
`timescale 1ns/1ps
module ssio_edge_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Only the second stage looks at the first one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_o = sync_reg;
    assign rise_o = sync_reg & ~last_reg;
    assign fall_o = ~sync_reg & last_reg;
endmodule

// ==== ssio_channel_sva.sv ====
// Checker for the serial channel, watching its top-level ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module ssio_channel_sva
    import ssio_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [SSIO_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_data_pin_oe_o,
    input wire logic tx_sync_pin_oe_o,
    input wire logic tx_empty_irq_o,
    input wire logic rx_full_irq_o,
    input wire logic tx_overrun_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic req;
    logic ctl_wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ctl_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == SSIO_OFS_CONTROL;
    a_ack_follows: assert property (req |=> wb_ack_o)
        else $error("no acknowledge after a request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_ctl_reserved: assert property (req && !wb_we_i && wb_adr_i == SSIO_OFS_CONTROL
        |=> wb_dat_o[31:7] == 25'h0) else $error("control reserved bits not zero");
    a_flag_reserved: assert property (req && !wb_we_i && wb_adr_i == SSIO_OFS_FLAGS
        |=> wb_dat_o[31:4] == 28'h0) else $error("flag reserved bits not zero");
    a_te_drives: assert property (ctl_wr |=> tx_data_pin_oe_o == $past(wb_dat_i[1]))
        else $error("data driver does not follow transmit enable");
    a_sync_drives: assert property (ctl_wr |=> tx_sync_pin_oe_o ==
        ($past(wb_dat_i[1]) && $past(wb_dat_i[6]))) else $error("sync driver wrong");
    a_tie_masks: assert property (ctl_wr && !wb_dat_i[3] |=> !tx_empty_irq_o)
        else $error("empty request while disabled");
    a_rie_masks: assert property (ctl_wr && !wb_dat_i[2] |=> !rx_full_irq_o)
        else $error("full request while disabled");
    a_reset_quiet: assert property ($fell(rst_i) |-> !tx_data_pin_oe_o &&
        !tx_empty_irq_o && !tx_overrun_irq_o) else $error("outputs active after reset");
    a_ovr_in_tx: assert property ($rose(tx_overrun_irq_o) |-> tx_data_pin_oe_o)
        else $error("transmit overrun without transmit enable");
    c_internal_sync: cover property (ctl_wr && wb_dat_i[6]);
    c_tx_overrun: cover property ($rose(tx_overrun_irq_o));
    c_rx_full: cover property ($rose(rx_full_irq_o));
endmodule

// ==== ssio_peer.sv ====
// Codec-like peer: makes one bit clock for both directions, the sync level and receive data.
// Assumes the bench calls frame() from one process at a time.
`timescale 1ns/1ps
module ssio_peer (
    output logic clk_o,
    output logic sync_o,
    output logic data_o,
    input wire logic data_i
);
    initial begin
        clk_o = 1'b0;
        sync_o = 1'b0;
        data_o = 1'b0;
    end
    // Data changes mid low phase so the synchronised fall never races it.
    task automatic frame(input logic [15:0] rw, input int n, input logic s,
                         output logic [15:0] tw);
        tw = 16'h0000;
        #7;
        for (int i = 0; i < n; i++) begin
            #80 data_o = rw[(n-1-i) & 15];
            sync_o = s && (i == 0);
            #80 clk_o = 1'b1;
            #155 tw = {tw[14:0], data_i};
            #5 clk_o = 1'b0;
        end
        // The clock stands still; the idle data line shows the inverse.
        #80 data_o = ~data_o;
        sync_o = 1'b0;
    endtask
endmodule

// ==== ssio_channel_bench.sv ====
// Self-checking bench for the serial channel with a codec-like peer.
// Assumes ssio_peer and the checker; clock 25 MHz, link clock 320 ns.
`timescale 1ns/1ps
module ssio_channel_bench;
    import ssio_pkg::*;
    localparam logic [3:0] A_RX = SSIO_OFS_RX_HOLD;
    localparam logic [3:0] A_TX = SSIO_OFS_TX_HOLD;
    localparam logic [3:0] A_CT = SSIO_OFS_CONTROL;
    localparam logic [3:0] A_FL = SSIO_OFS_FLAGS;
    logic clk_i, rst_i, cyc, stb, we;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat;
    logic ack, txd, txd_oe, sy_o, sy_oe, ti, ri, tov, rov;
    logic pclk, psync, pdat;
    logic sy_last = 1'b0;
    int syncs = 0;
    wire logic tx_wire;
    wire logic sync_wire;
    int failures;
    int checked;
    assign tx_wire = txd_oe ? txd : 1'bz;
    assign sync_wire = sy_oe ? sy_o : psync;
    ssio_channel i_ssio_channel (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .tx_data_pin_o(txd), .tx_data_pin_oe_o(txd_oe),
        .tx_clock_pin_i(pclk), .tx_sync_pin_i(sync_wire), .tx_sync_pin_o(sy_o),
        .tx_sync_pin_oe_o(sy_oe), .rx_data_pin_i(pdat), .rx_clock_pin_i(pclk),
        .rx_sync_pin_i(psync), .tx_empty_irq_o(ti), .rx_full_irq_o(ri),
        .tx_overrun_irq_o(tov), .rx_overrun_irq_o(rov));
    ssio_peer i_ssio_peer (.clk_o(pclk), .sync_o(psync), .data_o(pdat), .data_i(tx_wire));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        sy_last <= sy_o;
        if (sy_o === 1'b1 && sy_last !== 1'b1) begin
            syncs <= syncs + 1;
        end
    end
    task automatic finish_test;
        $display("checks %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(nm, q, {16'h0000, e});
    endtask
    // Flags clear only after being read as one, so read first, then write zero.
    task automatic clr(input logic [15:0] e);
        rd(A_FL, e, "flags");
        wr(A_FL, 16'h0000);
    endtask
    task automatic xfer(input logic dl, input logic s, input logic [15:0] r,
                        output logic [15:0] t);
        i_ssio_peer.frame(r, dl ? 16 : 8, s, t);
        repeat (8) @(posedge clk_i);
    endtask
    function automatic logic [15:0] low(input logic [15:0] v, input logic dl);
        return dl ? v : {8'h00, v[7:0]};
    endfunction
    initial begin
        #1000000;
        failures++;
        finish_test;
    end
    initial begin
        logic dl;
        logic [1:0] ie;
        logic [15:0] w, r, t;
        int s0;
        {cyc, stb, we, adr, sel, wdat} = '0;
        rst_i = 1'b1;
        failures = 0;
        checked = 0;
        void'($urandom(50));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_FL, 16'h0002, "flags");
        rd(A_CT, 16'h0000, "control");
        rd(A_TX, 16'h0000, "tx hold");
        rd(A_RX, 16'h0000, "rx hold");
        rd(4'h2, 16'h0000, "unmapped");
        chk("drivers", {30'h0, txd_oe, sy_oe}, 32'h0);
        wr(A_CT, 16'hff80);
        rd(A_CT, 16'h0000, "control");
        wr(A_FL, 16'hfff0);
        rd(A_FL, 16'h0002, "flags");
        wr(A_CT, 16'h0002);
        clr(16'h0002);
        wr(A_FL, 16'h0002);
        rd(A_FL, 16'h0000, "flags");
        wr(A_CT, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            dl = k[1];
            ie = 2'($urandom);
            w = 16'($urandom);
            r = 16'($urandom);
            wr(A_CT, {9'h000, 1'b0, 1'b1, dl, ie, 2'b11});
            wr(A_TX, w);
            clr(16'h0002);
            xfer(dl, 1'b1, r, t);
            chk("tx word", {16'h0000, t}, {16'h0000, low(w, dl)});
            rd(A_RX, low(r, dl), "rx hold");
            chk("requests", {30'h0, ti, ri}, {30'h0, ie});
            clr(16'h0003);
            wr(A_CT, 16'h0000);
            rd(A_FL, 16'h0002, "flags");
        end
        wr(A_CT, 16'h0033);
        wr(A_TX, 16'h1234);
        wr(A_TX, w);
        clr(16'h0002);
        xfer(1'b1, 1'b1, r, t);
        chk("tx word", {16'h0000, t}, {16'h0000, w});
        xfer(1'b1, 1'b1, ~r, t);
        rd(A_FL, 16'h000f, "flags");
        chk("overruns", {30'h0, tov, rov}, 32'h3);
        rd(A_RX, ~r, "rx hold");
        clr(16'h000f);
        rd(A_FL, 16'h0000, "flags");
        xfer(1'b1, 1'b0, r, t);
        rd(A_FL, 16'h0000, "flags");
        wr(A_CT, 16'h0000);
        wr(A_CT, 16'h0013);
        wr(A_TX, w);
        clr(16'h0002);
        xfer(1'b1, 1'b1, r, t);
        chk("tx word", {16'h0000, t}, {16'h0000, w});
        w = 16'($urandom);
        wr(A_TX, w);
        clr(16'h0003);
        xfer(1'b1, 1'b0, ~r, t);
        chk("tx word", {16'h0000, t}, {16'h0000, w});
        rd(A_RX, ~r, "rx hold");
        wr(A_CT, 16'h0000);
        wr(A_CT, 16'h0072);
        chk("drivers", {30'h0, txd_oe, sy_oe}, 32'h3);
        wr(A_TX, w);
        clr(16'h0002);
        s0 = syncs;
        i_ssio_peer.frame(r, 17, 1'b0, t);
        repeat (8) @(posedge clk_i);
        chk("sync seen", syncs - s0, 32'h1);
        chk("tx word", {16'h0000, t}, {16'h0000, w});
        rd(A_FL, 16'h0002, "flags");
        wr(A_CT, 16'h0000);
        chk("drivers", {30'h0, txd_oe, sy_oe}, 32'h0);
        finish_test;
    end
endmodule
bind ssio_channel ssio_channel_sva i_ssio_channel_sva (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_data_pin_oe_o(tx_data_pin_oe_o), .tx_sync_pin_oe_o(tx_sync_pin_oe_o),
    .tx_empty_irq_o(tx_empty_irq_o), .rx_full_irq_o(rx_full_irq_o),
    .tx_overrun_irq_o(tx_overrun_irq_o));
